// >>> common/qaw_pkg.sv
package qaw_pkg;

    // Clock rate and watchdog cycle times
    localparam int unsigned QAW_MCLK_MHZ         = 125;
    localparam int unsigned QAW_CYCLE_SHORT_US   = 100;
    localparam int unsigned QAW_CYCLE_LONG_US    = 1000;
    localparam int unsigned QAW_CYCLE_SHORT_CLKS = QAW_CYCLE_SHORT_US * QAW_MCLK_MHZ;
    localparam int unsigned QAW_CYCLE_LONG_CLKS  = QAW_CYCLE_LONG_US * QAW_MCLK_MHZ;
    localparam int unsigned QAW_TICK_W           = 17;

    // Widths
    localparam int unsigned QAW_QUEST_W = 4;
    localparam int unsigned QAW_BYTE_W  = 8;
    localparam int unsigned QAW_FAIL_W  = 5;
    localparam int unsigned QAW_THR_W   = 4;
    localparam int unsigned QAW_HB_W    = 8;

    // Write targets on the link
    localparam logic [1:0] QAW_TGT_RSP  = 2'h0;
    localparam logic [1:0] QAW_TGT_SYNC = 2'h1;
    localparam logic [1:0] QAW_TGT_CFG0 = 2'h2;
    localparam logic [1:0] QAW_TGT_CFG1 = 2'h3;

    // watchdog_config_reg0 field positions
    localparam int unsigned QAW_CFG0_EN_BIT  = 0;
    localparam int unsigned QAW_CFG0_CYC_BIT = 1;
    localparam int unsigned QAW_CFG0_THR_LSB = 4;

    // Reset values
    localparam logic                 QAW_EN_RST    = 1'b0;
    localparam logic                 QAW_CYC_RST   = 1'b0;
    localparam logic [QAW_THR_W-1:0] QAW_THR_RST   = 4'h1;
    localparam logic [QAW_HB_W-1:0]  QAW_HBCNT_RST = 8'h0a;
    localparam logic [7:0]           QAW_LFSR_RST  = 8'h01;

    // Operating states that allow configuration
    localparam logic [2:0] QAW_OPS_INIT   = 3'h1;
    localparam logic [2:0] QAW_OPS_NORMAL = 3'h2;
    localparam logic [2:0] QAW_OPS_WAKE   = 3'h3;

    // Run state of the watchdog
    typedef enum logic [1:0] {
        QAW_OFF = 2'b01,
        QAW_RUN = 2'b10
    } qaw_run_e;

    // Expected answers, byte 3 in the top lane
    localparam logic [31:0] QAW_ANSWER_TABLE [16] = '{
        32'hff0ff000, 32'hb040bf4f, 32'he919e616, 32'ha656a959,
        32'h75857a8a, 32'h3aca35c5, 32'h63936c9c, 32'h2cdc23d3,
        32'hd222dd2d, 32'h9d6d9262, 32'hc434cb3b, 32'h8b7b8474,
        32'h58a857a7, 32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe
    };

endpackage

// >>> rtl/qaw_sync.sv
`timescale 1ns/10ps
module qaw_sync #(
    parameter int unsigned W = 1
) (
    // Destination clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Asynchronous input and synchronised output
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// >>> rtl/qaw_watchdog.sv
`timescale 1ns/10ps
// What this block does
// - Question is 4 bits; answer is four 8-bit response bytes.
// - Synchronized last response byte restarts the heartbeat counter from zero, counting up.
// - Watchdog disabled after power-up until software sets its enable bit.
// - Configuration writes accepted only in init, normal or wake state.
// - Heartbeat period is cycle time times programmed cycle count; a count of 0 acts as 1.
// - Cycle time selectable 100 us or 1000 us, 1000 us default.
// - Failure counter overflow threshold is programmable.
// - Fixed table of four expected bytes per question, byte 3 first.
// - Response position counter readable; host reads it before each write.
// - Correct ordered answer is valid; failure counter down one if nonzero.
// - Correct answer clears heartbeat only when last byte was synchronized.
// - Complete answer with any bad byte is invalid; failure counter up two.
// - Wrong answer with synchronized last byte also restarts the heartbeat.
// - Failure counter above threshold: move-to-init, heartbeat and counter cleared.
// - Correct plain-ended answer is valid, new question, heartbeat keeps running.
// - Heartbeat expiry is invalid: counter up two, heartbeat restarted.
// - Invalid triggering keeps the question; only a valid answer loads a new one.
// - Each byte checked against its own position; swaps fail both.
// - Synchronized write ends the answer only as the fourth byte.
// - Verdict stays internal, feeding the failure counter and the question update.
module qaw_watchdog
    import qaw_pkg::*;
#(
    parameter int unsigned CYCLE_SHORT_CLKS = QAW_CYCLE_SHORT_CLKS,
    parameter int unsigned CYCLE_LONG_CLKS  = QAW_CYCLE_LONG_CLKS
) (
    // System clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // Link side register writes
    input  wire logic                  link_clk,
    input  wire logic                  link_wr_strobe,
    input  wire logic [1:0]            link_wr_target,
    input  wire logic [QAW_BYTE_W-1:0] link_wr_data,
    // Device operating state
    input  wire logic [2:0]            op_state,
    // Configuration readback
    output logic                       qa_watchdog_enable,
    output logic                       cycle_time_select,
    output logic [QAW_HB_W-1:0]        heartbeat_cycle_count,
    output logic [QAW_THR_W-1:0]       failure_threshold,
    // Status
    output logic [QAW_QUEST_W-1:0]     current_question,
    output logic [1:0]                 response_position_counter,
    output logic [QAW_FAIL_W-1:0]      qa_failure_counter,
    output logic [QAW_HB_W-1:0]        heartbeat_count,
    output logic                       move_to_init
);

    // Link domain
    logic                  link_req_tgl_q;
    logic [1:0]            link_tgt_q;
    logic [QAW_BYTE_W-1:0] link_dat_q;

    // Crossing into mclk
    logic                  req_sync;
    logic                  req_seen_q;
    logic                  wr_take;
    logic                  wr_vld_q;
    logic [1:0]            wr_tgt_q;
    logic [QAW_BYTE_W-1:0] wr_dat_q;

    // Decode
    logic                  cfg_ok;
    logic                  cfg0_wr;
    logic                  cfg1_wr;
    logic                  rsp_wr;
    logic                  rsp_sync;

    // Run state
    qaw_run_e              state_q;
    logic                  running;

    // Timebase and heartbeat
    logic [QAW_TICK_W-1:0] cyc_q;
    logic [QAW_TICK_W-1:0] cyc_limit;
    logic                  tick;
    logic [QAW_HB_W-1:0]   hb_period;
    logic                  expire;
    logic                  hb_restart;

    // Answer tracking
    logic [7:0]            lfsr_q;
    logic [1:0]            pos_q;
    logic [1:0]            due_idx;
    logic                  mismatch_q;
    logic [QAW_BYTE_W-1:0] exp_byte;
    logic                  byte_bad;
    logic                  last_rsp;
    logic                  verdict_valid;
    logic                  verdict_invalid;

    // Failure counter
    logic [QAW_FAIL_W-1:0] fail_calc;
    logic                  overflow;

    // Link side capture; data holds until the next write
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_req_tgl_q <= 1'b0;
            link_tgt_q     <= QAW_TGT_RSP;
            link_dat_q     <= '0;
        end else if (link_wr_strobe) begin
            link_req_tgl_q <= ~link_req_tgl_q;
            link_tgt_q     <= link_wr_target;
            link_dat_q     <= link_wr_data;
        end
    end

    // Toggle crossing; data is quiet by the time the edge is seen
    qaw_sync #(
        .W       (1)
    ) u_req_sync (
        .clk     (mclk),
        .reset_n (reset_n),
        .d       (link_req_tgl_q),
        .q       (req_sync)
    );

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            req_seen_q <= 1'b0;
        end else begin
            req_seen_q <= req_sync;
        end
    end

    assign wr_take = req_sync ^ req_seen_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_vld_q <= 1'b0;
            wr_tgt_q <= QAW_TGT_RSP;
            wr_dat_q <= '0;
        end else begin
            wr_vld_q <= wr_take;
            if (wr_take) begin
                wr_tgt_q <= link_tgt_q;
                wr_dat_q <= link_dat_q;
            end
        end
    end

    assign cfg_ok = (op_state == QAW_OPS_INIT) || (op_state == QAW_OPS_NORMAL)
                 || (op_state == QAW_OPS_WAKE);

    assign cfg0_wr  = wr_vld_q && (wr_tgt_q == QAW_TGT_CFG0) && cfg_ok;
    assign cfg1_wr  = wr_vld_q && (wr_tgt_q == QAW_TGT_CFG1) && cfg_ok;
    assign rsp_sync = (wr_tgt_q == QAW_TGT_SYNC);
    assign rsp_wr   = wr_vld_q && running && ((wr_tgt_q == QAW_TGT_RSP) || rsp_sync);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            qa_watchdog_enable <= QAW_EN_RST;
        end else if (cfg0_wr) begin
            qa_watchdog_enable <= wr_dat_q[QAW_CFG0_EN_BIT];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cycle_time_select <= QAW_CYC_RST;
            failure_threshold <= QAW_THR_RST;
        end else if (cfg0_wr) begin
            cycle_time_select <= wr_dat_q[QAW_CFG0_CYC_BIT];
            failure_threshold <= wr_dat_q[QAW_CFG0_THR_LSB +: QAW_THR_W];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            heartbeat_cycle_count <= QAW_HBCNT_RST;
        end else if (cfg1_wr) begin
            heartbeat_cycle_count <= wr_dat_q;
        end
    end

    // Run state follows the enable bit
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= QAW_OFF;
        end else begin
            unique case (state_q)
                QAW_OFF: begin
                    if (qa_watchdog_enable) begin
                        state_q <= QAW_RUN;
                    end
                end
                QAW_RUN: begin
                    if (!qa_watchdog_enable) begin
                        state_q <= QAW_OFF;
                    end
                end
                default: begin
                    state_q <= QAW_OFF;
                end
            endcase
        end
    end

    assign running = (state_q == QAW_RUN);

    assign cyc_limit = cycle_time_select ? QAW_TICK_W'(CYCLE_SHORT_CLKS - 1)
                                         : QAW_TICK_W'(CYCLE_LONG_CLKS - 1);
    // Compare is >= so a shorter tick picked mid-count cannot wrap
    assign tick      = running && (cyc_q >= cyc_limit);

    // Timebase restarts with the heartbeat so a period is whole ticks
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cyc_q <= '0;
        end else if (!running || hb_restart || tick) begin
            cyc_q <= '0;
        end else begin
            cyc_q <= cyc_q + 1'b1;
        end
    end

    assign hb_period = (heartbeat_cycle_count == '0) ? QAW_HB_W'(1) : heartbeat_cycle_count;

    // expiry, deferred while a response is taken
    assign expire = running && (heartbeat_count >= hb_period) && !rsp_wr;

    assign hb_restart = (last_rsp && rsp_sync) || expire || overflow;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            heartbeat_count <= '0;
        end else if (!running || hb_restart) begin
            heartbeat_count <= '0;
        end else if (tick && (heartbeat_count < hb_period)) begin
            heartbeat_count <= heartbeat_count + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lfsr_q <= QAW_LFSR_RST;
        end else begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            current_question <= '0;
        end else if (verdict_valid) begin
            current_question <= lfsr_q[QAW_QUEST_W-1:0];
        end
    end

    assign due_idx  = 2'h3 - pos_q;
    assign exp_byte = QAW_ANSWER_TABLE[current_question][{due_idx, 3'h0} +: QAW_BYTE_W];
    assign byte_bad = (wr_dat_q != exp_byte);

    assign last_rsp = rsp_wr && (pos_q == 2'h3);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pos_q <= '0;
        end else if (!running || expire) begin
            pos_q <= '0;
        end else if (rsp_wr) begin
            pos_q <= pos_q + 1'b1;
        end
    end

    assign response_position_counter = pos_q;

    // any bad byte spoils the answer
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mismatch_q <= 1'b0;
        end else if (!running || expire || last_rsp) begin
            mismatch_q <= 1'b0;
        end else if (rsp_wr && byte_bad) begin
            mismatch_q <= 1'b1;
        end
    end

    assign verdict_valid   = last_rsp && !mismatch_q && !byte_bad;
    assign verdict_invalid = (last_rsp && (mismatch_q || byte_bad)) || expire;

    always_comb begin
        fail_calc = qa_failure_counter;
        if (verdict_valid && (qa_failure_counter != '0)) begin
            fail_calc = qa_failure_counter - 1'b1;
        end else if (verdict_invalid) begin
            fail_calc = qa_failure_counter + QAW_FAIL_W'(2);
        end
    end

    assign overflow = running && (fail_calc > {1'b0, failure_threshold});

    // Counter width holds threshold plus two, so it never wraps
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            qa_failure_counter <= '0;
        end else if (!running || overflow) begin
            qa_failure_counter <= '0;
        end else begin
            qa_failure_counter <= fail_calc;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            move_to_init <= 1'b0;
        end else begin
            move_to_init <= overflow;
        end
    end

endmodule

// >>> bench/qaw_watchdog_monitor.sv
`timescale 1ns/10ps
module qaw_watchdog_monitor
    import qaw_pkg::*;
(
    // Clock and reset
    input wire logic                   mclk,
    input wire logic                   reset_n,
    // Watched outputs
    input wire logic                   qa_watchdog_enable,
    input wire logic [QAW_HB_W-1:0]    heartbeat_cycle_count,
    input wire logic [QAW_THR_W-1:0]   failure_threshold,
    input wire logic [QAW_QUEST_W-1:0] current_question,
    input wire logic [1:0]             response_position_counter,
    input wire logic [QAW_FAIL_W-1:0]  qa_failure_counter,
    input wire logic [QAW_HB_W-1:0]    heartbeat_count,
    input wire logic                   move_to_init
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    property p_mti_pulse; move_to_init |=> !move_to_init; endproperty
    a_mti_pulse: assert property (p_mti_pulse) else $error("move to init too wide");
    property p_mti_clear;
        move_to_init |-> qa_failure_counter == 0 && heartbeat_count == 0;
    endproperty
    a_mti_clear: assert property (p_mti_clear) else $error("counters not cleared");
    property p_overflow;
        $past(qa_watchdog_enable) && qa_watchdog_enable && $past(qa_failure_counter) > 1
            && qa_failure_counter == 0 |-> move_to_init;
    endproperty
    a_overflow: assert property (p_overflow) else $error("no move to init");
    property p_fail_step;
        $changed(qa_failure_counter) |-> qa_failure_counter == 0
            || qa_failure_counter == $past(qa_failure_counter) - 1
            || qa_failure_counter == $past(qa_failure_counter) + 2;
    endproperty
    a_fail_step: assert property (p_fail_step) else $error("bad failure step");
    property p_fail_limit;
        qa_failure_counter > $past(qa_failure_counter) |-> qa_failure_counter <= failure_threshold;
    endproperty
    a_fail_limit: assert property (p_fail_limit) else $error("failure above limit");
    property p_keep_question;
        qa_failure_counter == $past(qa_failure_counter) + 2 |-> $stable(current_question);
    endproperty
    a_keep_question: assert property (p_keep_question) else $error("question moved");
    property p_off_idle;
        !qa_watchdog_enable [*3] |->
            qa_failure_counter == 0 && heartbeat_count == 0 && response_position_counter == 0;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("active while disabled");
    property p_hb_step;
        $changed(heartbeat_count) |-> heartbeat_count == 0
            || heartbeat_count == $past(heartbeat_count) + 1;
    endproperty
    a_hb_step: assert property (p_hb_step) else $error("heartbeat jumped");
    // expiry restarts heartbeat; response may defer it one cycle
    property p_hb_expire;
        qa_watchdog_enable && heartbeat_count != 0 && heartbeat_count >= heartbeat_cycle_count
            |-> ##[1:3] heartbeat_count == 0;
    endproperty
    a_hb_expire: assert property (p_hb_expire) else $error("heartbeat overran");
    property p_pos_step;
        $changed(response_position_counter) |-> response_position_counter == 0
            || response_position_counter == $past(response_position_counter) + 1;
    endproperty
    a_pos_step: assert property (p_pos_step) else $error("position jumped");

    c_overflow: cover property (move_to_init);
    c_valid: cover property (qa_failure_counter == $past(qa_failure_counter) - 1);
    c_expire: cover property (qa_watchdog_enable && $fell(heartbeat_count != 0));
endmodule

bind qaw_watchdog qaw_watchdog_monitor u_mon (
    .mclk(mclk), .reset_n(reset_n), .qa_watchdog_enable(qa_watchdog_enable),
    .heartbeat_cycle_count(heartbeat_cycle_count), .failure_threshold(failure_threshold),
    .current_question(current_question), .response_position_counter(response_position_counter),
    .qa_failure_counter(qa_failure_counter), .heartbeat_count(heartbeat_count),
    .move_to_init(move_to_init)
);

// >>> bench/qaw_host_model.sv
`timescale 1ns/10ps
module qaw_host_model (
    // Link write port
    output logic       link_clk,
    output logic       link_wr_strobe,
    output logic [1:0] link_wr_target,
    output logic [7:0] link_wr_data
);
    initial begin
        link_clk = 1'b0;
        link_wr_strobe = 1'b0;
        link_wr_target = 2'h0;
        link_wr_data = 8'h5a;
    end
    // one write per link cycle; clock stands still between writes
    task automatic send(input logic [1:0] tgt, input logic [7:0] dat);
        link_wr_strobe = 1'b1;
        link_wr_target = tgt;
        link_wr_data = dat;
        #29 link_clk = 1'b1;
        #32 link_clk = 1'b0;
        // Released lines show garbage so stale data cannot pass
        link_wr_strobe = 1'b0;
        link_wr_target = ~tgt;
        link_wr_data = ~dat;
        #5;
    endtask
endmodule

// >>> bench/qaw_watchdog_bench.sv
`timescale 1ns/10ps
module qaw_watchdog_bench
    import qaw_pkg::*;
;
    typedef struct packed {
        logic [3:0] bad;
        logic       swap;
        logic [3:0] syncm;
        logic       ok;
        logic       hbclr;
    } qaw_row_s;
    logic mclk, reset_n, link_clk, link_wr_strobe, en, cyc, mti, mti_seen;
    logic [1:0] link_wr_target, pos;
    logic [7:0] link_wr_data, hbcc, hb, h;
    logic [2:0] op_state;
    logic [3:0] thr, quest, q;
    logic [4:0] fail, f, ef;
    int miscompares, checked, cycles, n;
    // expected bytes, byte 3 on top
    logic [31:0] ans [16] = '{32'hff0ff000, 32'hb040bf4f, 32'he919e616, 32'ha656a959,
        32'h75857a8a, 32'h3aca35c5, 32'h63936c9c, 32'h2cdc23d3, 32'hd222dd2d, 32'h9d6d9262,
        32'hc434cb3b, 32'h8b7b8474, 32'h58a857a7, 32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe};
    qaw_row_s rows [6] = '{'{4'h0, 1'b0, 4'h1, 1'b1, 1'b1}, '{4'h2, 1'b0, 4'h1, 1'b0, 1'b1},
        '{4'h0, 1'b1, 4'h1, 1'b0, 1'b1}, '{4'h0, 1'b0, 4'h0, 1'b1, 1'b0},
        '{4'h1, 1'b0, 4'h0, 1'b0, 1'b0}, '{4'h0, 1'b0, 4'h2, 1'b1, 1'b0}};

    // Short tick counts keep the run brief
    qaw_watchdog #(.CYCLE_SHORT_CLKS(8), .CYCLE_LONG_CLKS(16)) uut (
        .mclk(mclk), .reset_n(reset_n), .link_clk(link_clk), .link_wr_strobe(link_wr_strobe),
        .link_wr_target(link_wr_target), .link_wr_data(link_wr_data), .op_state(op_state),
        .qa_watchdog_enable(en), .cycle_time_select(cyc), .heartbeat_cycle_count(hbcc),
        .failure_threshold(thr), .current_question(quest), .response_position_counter(pos),
        .qa_failure_counter(fail), .heartbeat_count(hb), .move_to_init(mti));
    qaw_host_model host (.link_clk(link_clk), .link_wr_strobe(link_wr_strobe),
        .link_wr_target(link_wr_target), .link_wr_data(link_wr_data));

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (mti === 1'b1) begin
            mti_seen = 1'b1;
        end
        if (cycles > 5000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Settle past the two-stage crossing
    task automatic wr(input logic [1:0] t, input logic [7:0] d);
        host.send(t, d);
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic answer(input qaw_row_s r);
        logic [31:0] a;
        a = ans[quest];
        if (r.swap) begin
            a = {a[31:24], a[15:8], a[23:16], a[7:0]};
        end
        for (int k = 3; k >= 0; k--) begin
            cmp(8'(pos), 8'(3 - k));
            wr(r.syncm[k] ? QAW_TGT_SYNC : QAW_TGT_RSP, a[8*k+:8] ^ {8{r.bad[k]}});
        end
    endtask
    task automatic stop_test();
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        op_state = QAW_OPS_NORMAL;
        mti_seen = 1'b0;
        repeat (16) @(posedge mclk);
        #1 reset_n = 1'b1;
        cmp({en, cyc, 2'h0, thr}, 8'h01);
        cmp(8'(quest), 8'h00);
        cmp(hbcc, 8'h0a);
        wr(QAW_TGT_RSP, 8'hff);
        cmp(8'(pos), 8'h00);
        op_state = 3'h0;
        wr(QAW_TGT_CFG1, 8'h20);
        cmp(hbcc, 8'h0a);
        op_state = QAW_OPS_WAKE;
        wr(QAW_TGT_CFG1, 8'h20);
        wr(QAW_TGT_CFG0, 8'hf1);
        cmp(8'({en, cyc, thr}), 8'h2f);
        foreach (rows[i]) begin
            f = fail;
            q = quest;
            h = hb;
            answer(rows[i]);
            ef = rows[i].ok ? ((f == 0) ? f : f - 5'h01) : f + 5'h02;
            cmp(8'(fail), 8'(ef));
            if (!rows[i].ok) cmp(8'(quest), 8'(q));
            if (rows[i].hbclr) cmp(hb, 8'h00);
            else cmp(8'(hb >= h), 8'h01);
        end
        f = fail;
        q = quest;
        for (n = 0; fail === f && n < 1000; n++) begin
            @(posedge mclk);
            #1;
        end
        cmp(8'({fail, 3'h0}), 8'({f + 5'h02, 3'h0}));
        cmp(8'({quest, hb[3:0]}), 8'({q, 4'h0}));
        wr(QAW_TGT_CFG0, 8'h11);
        // Lowered threshold is already exceeded; clear the flag for the answer case
        cmp(8'({fail, mti_seen}), 8'h01);
        mti_seen = 1'b0;
        answer(rows[1]);
        repeat (2) @(posedge mclk);
        #1;
        cmp(8'({fail, mti_seen}), 8'h01);
        wr(QAW_TGT_CFG0, 8'hf3);
        cmp(8'(cyc), 8'h01);
        h = hb;
        for (n = 0; hb === h && n < 100; n++) begin
            @(posedge mclk);
            #1;
        end
        h = hb;
        for (n = 0; hb === h && n < 100; n++) begin
            @(posedge mclk);
            #1;
        end
        cmp(8'(n), 8'h08);
        // Reset mid-run brings every output back to its reset value
        reset_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1'b1;
        cmp({en, cyc, 2'h0, thr}, 8'h01);
        cmp(8'(quest), 8'h00);
        cmp({fail, pos, mti}, 8'h00);
        cmp(hb, 8'h00);
        cmp(hbcc, 8'h0a);
        stop_test();
    end
endmodule
